// *** rtl/pmbw_pkg.sv ***
// constants shared by both ends of the local-to-PCI burst write path
// How it works
// - local request seen, assert PCI bus request
// - grant and idle bus, assert local grant
// - request and grant seen, show address loading
// - master drops request after address loading shown
// - then assert frame, drive address and command
// - same cycle, status becomes bus transaction
// - load burst counter during address phase
// - master presents word after ready cycle
// - master holds ready only while data available
// - drop bus request cycle after frame asserted
// - strobe first word capture after ready and grant, later words after ready and trdy
// - after address phase of a burst longer than one word: frame, irdy, no strobe
// - keep irdy asserted while words keep coming
// - irdy and trdy complete phase, count down
// - after accepted phase drive next staged word
// - master drops ready on its final word
// - final phase releases frame, strobe off
// - turnaround releases pins, irdy high, count zero
// - target drops devsel and trdy at turnaround
// - idle after turnaround releases irdy and par
package pmbw_pkg;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BURST_W = 8;
  localparam int FIFO_DEPTH = 2;
  localparam logic [3:0] ST_CODE_IDLE = 4'h0;
  localparam logic [3:0] ST_CODE_ADDR_LOAD = 4'h1;
  localparam logic [3:0] ST_CODE_BUS_TRANS = 4'h2;
  localparam logic [3:0] ST_CODE_BUS_TERM = 4'h3;
  localparam logic [1:0] TERM_NONE = 2'h0;
  localparam logic [1:0] TERM_NORMAL = 2'h1;
endpackage : pmbw_pkg

// *** rtl/pmbw_if.sv ***
// interface joining the bridge end with the local master and PCI target end
`timescale 1ns/1ps
`default_nettype none
interface pmbw_if;
  logic local_req_32bit_n;
  logic [pmbw_pkg::DATA_W-1:0] local_ad_in;
  logic [pmbw_pkg::BE_W-1:0] local_cmd_byte_en_in;
  logic [pmbw_pkg::BURST_W-1:0] requested_burst_len;
  logic local_grant_n;
  logic [3:0] local_master_state;
  logic local_master_ready_n;
  logic local_word_taken_n;
  logic [pmbw_pkg::BURST_W-1:0] burst_remaining_count;
  logic [1:0] termination_kind;
  logic req_n;
  logic gnt_n;
  logic frame_n_o;
  logic frame_oe;
  logic irdy_n_o;
  logic irdy_oe;
  logic [pmbw_pkg::DATA_W-1:0] ad_o;
  logic ad_oe;
  logic [pmbw_pkg::BE_W-1:0] cbe_o;
  logic cbe_oe;
  logic par_o;
  logic par_oe;
  logic trdy_n;
  logic devsel_n;
  // resolved bus levels; undriven control lines read high as if pulled up
  logic frame_n;
  logic irdy_n;
  logic [pmbw_pkg::DATA_W-1:0] ad;
  logic [pmbw_pkg::BE_W-1:0] cbe;
  logic par;
  assign frame_n = frame_oe ? frame_n_o : 1'b1;
  assign irdy_n = irdy_oe ? irdy_n_o : 1'b1;
  assign ad = ad_oe ? ad_o : '0;
  assign cbe = cbe_oe ? cbe_o : '0;
  assign par = par_oe ? par_o : 1'b0;
  modport dev (
    input local_req_32bit_n, local_ad_in, local_cmd_byte_en_in, requested_burst_len,
    input local_master_ready_n, gnt_n, trdy_n, devsel_n, frame_n, irdy_n,
    output local_grant_n, local_master_state, local_word_taken_n, burst_remaining_count,
    output termination_kind, req_n, frame_n_o, frame_oe, irdy_n_o, irdy_oe,
    output ad_o, ad_oe, cbe_o, cbe_oe, par_o, par_oe
  );
  modport far (
    output local_req_32bit_n, local_ad_in, local_cmd_byte_en_in, requested_burst_len,
    output local_master_ready_n, gnt_n, trdy_n, devsel_n,
    input local_grant_n, local_master_state, local_word_taken_n, burst_remaining_count,
    input termination_kind, req_n, frame_n, irdy_n, ad, cbe, par
  );
endinterface : pmbw_if
`default_nettype wire

// *** rtl/pmbw_bridge.sv ***
// bridge end: PCI initiator for 32-bit burst writes from the local master
`timescale 1ns/1ps
`default_nettype none
module pmbw_bridge #(
  parameter int DEPTH = pmbw_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  pmbw_if.dev bus,
  output logic busy
);
  localparam int DW = pmbw_pkg::DATA_W;
  localparam int BW = pmbw_pkg::BE_W;
  localparam int LW = pmbw_pkg::BURST_W;
  localparam int EW = DW + BW;

  typedef enum logic [2:0] {S_IDLE, S_REQ, S_GRANT, S_LOAD, S_ADDR, S_DATA, S_TURN} pmbw_state_e;
  pmbw_state_e state_r;

  logic req_n_r, grant_n_r, taken_n_r;
  logic [3:0] status_r;
  logic [1:0] term_r;
  logic [LW-1:0] cnt_r, len_r, taken_cnt_r;
  logic frame_n_r, frame_oe_r, irdy_n_r, irdy_oe_r, ad_oe_r, cbe_oe_r, par_r, par_oe_r;
  logic [DW-1:0] ad_r, addr_r;
  logic [BW-1:0] cbe_r, cmd_r;

  // two-entry staging buffer between local capture and the PCI data lines
  logic [EW-1:0] mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_r, rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] count_r;
  logic push, pop, fifo_valid, complete, load_slot, last_phase, strobe_nxt, store, deq;
  logic [EW-1:0] head;
  logic [$clog2(DEPTH+1):0] fill;
  logic [LW-1:0] cnt_after;

  assign complete = (state_r == S_DATA) && !irdy_n_r && !bus.trdy_n;
  assign last_phase = complete && (cnt_r == LW'(1));
  assign fifo_valid = (count_r != '0);
  assign push = !taken_n_r;
  assign load_slot = (state_r == S_ADDR) || (state_r == S_DATA && (irdy_n_r || complete) && !last_phase);
  assign pop = load_slot && (fifo_valid || push);
  // an empty buffer hands a captured word straight to the lines, so irdy follows a capture by one cycle
  assign deq = pop && fifo_valid;
  assign store = push && !(pop && !fifo_valid);
  assign head = fifo_valid ? mem_r[rd_ptr_r] : {bus.local_cmd_byte_en_in, bus.local_ad_in};
  assign cnt_after = complete ? cnt_r - LW'(1) : cnt_r;
  assign fill = ($clog2(DEPTH+1)+1)'(count_r) + ($clog2(DEPTH+1)+1)'(push) - ($clog2(DEPTH+1)+1)'(pop);

  // strobes never come back to back: the master refills its word one cycle after a capture
  always_comb begin
    strobe_nxt = 1'b0;
    if (taken_n_r && !bus.local_master_ready_n && (taken_cnt_r + LW'(push) < len_r) &&
        (fill < ($clog2(DEPTH+1)+1)'(DEPTH))) begin
      if (state_r == S_LOAD && !bus.gnt_n)
        strobe_nxt = 1'b1;
      else if (state_r == S_ADDR || state_r == S_DATA)
        strobe_nxt = !bus.trdy_n || (count_r == '0 && irdy_n_r);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: if (!bus.local_req_32bit_n) state_r <= S_REQ;
        S_REQ: if (!bus.gnt_n && bus.frame_n && bus.irdy_n) state_r <= S_GRANT;
        S_GRANT: state_r <= bus.local_req_32bit_n ? S_IDLE : S_LOAD;
        S_LOAD: state_r <= bus.gnt_n ? S_REQ : S_ADDR;
        S_ADDR: state_r <= S_DATA;
        S_DATA: if (last_phase) state_r <= S_TURN;
        S_TURN: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // arbitration handshake on both sides
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_n_r <= 1'b1;
      grant_n_r <= 1'b1;
    end else begin
      if (state_r == S_IDLE && !bus.local_req_32bit_n)
        req_n_r <= 1'b0;
      else if (state_r == S_ADDR)
        req_n_r <= 1'b1;
      if (state_r == S_REQ && !bus.gnt_n && bus.frame_n && bus.irdy_n)
        grant_n_r <= 1'b0;
      else if (state_r == S_ADDR || state_r == S_IDLE || (state_r == S_LOAD && bus.gnt_n) ||
               (state_r == S_GRANT && bus.local_req_32bit_n))
        grant_n_r <= 1'b1;
    end
  end

  // status, termination, latched request, burst counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= pmbw_pkg::ST_CODE_IDLE;
      term_r <= pmbw_pkg::TERM_NONE;
      addr_r <= '0;
      cmd_r <= '0;
      len_r <= '0;
      cnt_r <= '0;
    end else begin
      case (state_r)
        S_GRANT: if (!bus.local_req_32bit_n && !grant_n_r) begin
          status_r <= pmbw_pkg::ST_CODE_ADDR_LOAD;
          addr_r <= bus.local_ad_in;
          cmd_r <= bus.local_cmd_byte_en_in;
          len_r <= bus.requested_burst_len;
          term_r <= pmbw_pkg::TERM_NONE;
        end
        S_LOAD: if (!bus.gnt_n) begin
          status_r <= pmbw_pkg::ST_CODE_BUS_TRANS;
          cnt_r <= len_r;
        end else begin
          status_r <= pmbw_pkg::ST_CODE_IDLE;
        end
        S_DATA: begin
          cnt_r <= cnt_after;
          if (last_phase) begin
            status_r <= pmbw_pkg::ST_CODE_BUS_TERM;
            term_r <= pmbw_pkg::TERM_NORMAL;
          end
        end
        S_TURN: status_r <= pmbw_pkg::ST_CODE_IDLE;
        default: status_r <= status_r;
      endcase
    end
  end

  // local word capture strobe and count of words taken
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      taken_n_r <= 1'b1;
      taken_cnt_r <= '0;
    end else begin
      taken_n_r <= !strobe_nxt;
      if (state_r == S_GRANT)
        taken_cnt_r <= '0;
      else if (push)
        taken_cnt_r <= taken_cnt_r + LW'(1);
    end
  end

  // staging buffer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else begin
      if (store) begin
        mem_r[wr_ptr_r] <= {bus.local_cmd_byte_en_in, bus.local_ad_in};
        wr_ptr_r <= (wr_ptr_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (deq)
        rd_ptr_r <= (rd_ptr_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + ($clog2(DEPTH+1))'(store) - ($clog2(DEPTH+1))'(deq);
    end
  end

  // PCI pin drivers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_n_r <= 1'b1;
      frame_oe_r <= 1'b0;
      irdy_n_r <= 1'b1;
      irdy_oe_r <= 1'b0;
      ad_r <= '0;
      ad_oe_r <= 1'b0;
      cbe_r <= '0;
      cbe_oe_r <= 1'b0;
    end else begin
      if (state_r == S_LOAD && !bus.gnt_n) begin
        frame_n_r <= 1'b0;
        frame_oe_r <= 1'b1;
        ad_r <= addr_r;
        ad_oe_r <= 1'b1;
        cbe_r <= cmd_r;
        cbe_oe_r <= 1'b1;
      end else if (state_r == S_ADDR || state_r == S_DATA) begin
        irdy_oe_r <= 1'b1;
        if (last_phase) begin
          frame_oe_r <= 1'b0;
          ad_oe_r <= 1'b0;
          cbe_oe_r <= 1'b0;
          irdy_n_r <= 1'b1;
        end else if (pop) begin
          {cbe_r, ad_r} <= head;
          irdy_n_r <= 1'b0;
          if (cnt_after == LW'(1))
            frame_n_r <= 1'b1;
        end else if (load_slot) begin
          irdy_n_r <= 1'b1;
        end
      end else if (state_r == S_TURN) begin
        irdy_oe_r <= 1'b0;
        frame_n_r <= 1'b1;
      end
    end
  end

  // parity trails the lines it covers by one cycle, so it is released one cycle after them
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      par_r <= 1'b0;
      par_oe_r <= 1'b0;
    end else begin
      par_r <= ^{ad_r, cbe_r};
      par_oe_r <= ad_oe_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      busy <= 1'b0;
    else
      busy <= (state_r != S_IDLE) || !bus.local_req_32bit_n;
  end

  assign bus.req_n = req_n_r;
  assign bus.local_grant_n = grant_n_r;
  assign bus.local_master_state = status_r;
  assign bus.local_word_taken_n = taken_n_r;
  assign bus.burst_remaining_count = cnt_r;
  assign bus.termination_kind = term_r;
  assign bus.frame_n_o = frame_n_r;
  assign bus.frame_oe = frame_oe_r;
  assign bus.irdy_n_o = irdy_n_r;
  assign bus.irdy_oe = irdy_oe_r;
  assign bus.ad_o = ad_r;
  assign bus.ad_oe = ad_oe_r;
  assign bus.cbe_o = cbe_r;
  assign bus.cbe_oe = cbe_oe_r;
  assign bus.par_o = par_r;
  assign bus.par_oe = par_oe_r;
endmodule : pmbw_bridge
`default_nettype wire

// *** rtl/pmbw_far_end.sv ***
// far end: local master, simple arbiter and a PCI write target
`timescale 1ns/1ps
`default_nettype none
module pmbw_far_end (
  input wire logic core_clk,
  input wire logic rstn,
  pmbw_if.far bus,
  input wire logic usr_start,
  input wire logic [pmbw_pkg::DATA_W-1:0] usr_addr,
  input wire logic [pmbw_pkg::BE_W-1:0] usr_cmd,
  input wire logic [pmbw_pkg::BURST_W-1:0] usr_len,
  input wire logic usr_wvalid,
  input wire logic [pmbw_pkg::DATA_W-1:0] usr_wdata,
  input wire logic [pmbw_pkg::BE_W-1:0] usr_wbe,
  output logic usr_wready,
  output logic rx_valid,
  output logic [pmbw_pkg::DATA_W-1:0] rx_data,
  output logic [pmbw_pkg::BE_W-1:0] rx_be
);
  localparam int LW = pmbw_pkg::BURST_W;
  logic req_n_r, gnt_n_r, rdy_n_r, mode_data_r, valid_r, active_r, devsel_n_r, trdy_n_r;
  logic [pmbw_pkg::DATA_W-1:0] ad_r;
  logic [pmbw_pkg::BE_W-1:0] cbe_r;
  logic [LW-1:0] len_r, give_left_r, give_left_after, left_now;
  logic taken, take_user, valid_nxt, load_mode, data_open;

  // the bridge latches the address at the edge that ends a local grant cycle, so word one may replace it there
  assign load_mode = !bus.local_grant_n && !mode_data_r;
  assign data_open = mode_data_r || load_mode;
  assign left_now = load_mode ? len_r : give_left_r;
  assign taken = !bus.local_word_taken_n && valid_r;
  assign take_user = data_open && usr_wvalid && usr_wready;
  assign valid_nxt = take_user || (valid_r && !taken);
  assign give_left_after = taken ? left_now - LW'(1) : left_now;

  // arbiter parks the grant on whoever asks, one cycle later
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      gnt_n_r <= 1'b1;
    else
      gnt_n_r <= bus.req_n;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_n_r <= 1'b1;
      mode_data_r <= 1'b0;
      len_r <= '0;
      give_left_r <= '0;
    end else begin
      if (usr_start && req_n_r && !mode_data_r) begin
        req_n_r <= 1'b0;
        len_r <= usr_len;
      end else if (bus.local_master_state == pmbw_pkg::ST_CODE_ADDR_LOAD) begin
        req_n_r <= 1'b1;
      end
      if (load_mode)
        mode_data_r <= 1'b1;
      else if (bus.local_master_state == pmbw_pkg::ST_CODE_BUS_TERM)
        mode_data_r <= 1'b0;
      give_left_r <= give_left_after;
    end
  end

  // one word slot; address sits on the same lines until loading is shown
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ad_r <= '0;
      cbe_r <= '0;
      valid_r <= 1'b0;
      rdy_n_r <= 1'b1;
      usr_wready <= 1'b0;
    end else begin
      if (usr_start && req_n_r && !mode_data_r) begin
        ad_r <= usr_addr;
        cbe_r <= usr_cmd;
      end else if (take_user) begin
        ad_r <= usr_wdata;
        cbe_r <= usr_wbe;
      end
      valid_r <= valid_nxt;
      rdy_n_r <= !(valid_nxt && give_left_after != '0);
      if (data_open)
        usr_wready <= !valid_nxt && give_left_after > LW'(valid_nxt);
      else
        usr_wready <= !gnt_n_r && !req_n_r && !valid_r; // word one is wanted as the local grant shows
    end
  end

  // write target: claims on frame, always ready, lets go after the last phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_r <= 1'b0;
      devsel_n_r <= 1'b1;
      trdy_n_r <= 1'b1;
      rx_valid <= 1'b0;
      rx_data <= '0;
      rx_be <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (!active_r && !bus.frame_n) begin
        active_r <= 1'b1;
        devsel_n_r <= 1'b0;
        trdy_n_r <= 1'b0;
      end else if (active_r && !bus.irdy_n && !trdy_n_r) begin
        rx_valid <= 1'b1;
        rx_data <= bus.ad;
        rx_be <= bus.cbe;
        if (bus.frame_n) begin
          active_r <= 1'b0;
          devsel_n_r <= 1'b1;
          trdy_n_r <= 1'b1;
        end
      end
    end
  end

  assign bus.local_req_32bit_n = req_n_r;
  assign bus.local_ad_in = ad_r;
  assign bus.local_cmd_byte_en_in = cbe_r;
  assign bus.requested_burst_len = len_r;
  assign bus.local_master_ready_n = rdy_n_r;
  assign bus.gnt_n = gnt_n_r;
  assign bus.trdy_n = trdy_n_r;
  assign bus.devsel_n = devsel_n_r;
endmodule : pmbw_far_end
`default_nettype wire

// *** tb/pmbw_checker.sv ***
// concurrent checks on the signals joining the bridge and its far end
`timescale 1ns/1ps
`default_nettype none
module pmbw_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic local_req_32bit_n,
  input wire logic local_grant_n,
  input wire logic [3:0] local_master_state,
  input wire logic local_master_ready_n,
  input wire logic local_word_taken_n,
  input wire logic [pmbw_pkg::BURST_W-1:0] burst_remaining_count,
  input wire logic [1:0] termination_kind,
  input wire logic req_n,
  input wire logic gnt_n,
  input wire logic trdy_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic irdy_n_o,
  input wire logic irdy_oe,
  input wire logic frame_oe,
  input wire logic ad_oe,
  input wire logic cbe_oe,
  input wire logic par_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_req;
    !local_req_32bit_n && local_master_state == pmbw_pkg::ST_CODE_IDLE |=> !req_n;
  endproperty
  a_req: assert property (p_req) else $error("bus request missing");
  property p_grant;
    $fell(local_grant_n) |-> $past(!gnt_n) && $past(frame_n) && $past(irdy_n);
  endproperty
  a_grant: assert property (p_grant) else $error("local grant without idle bus");
  property p_load;
    $fell(local_grant_n) && !local_req_32bit_n |=> local_master_state == pmbw_pkg::ST_CODE_ADDR_LOAD;
  endproperty
  a_load: assert property (p_load) else $error("no address loading");
  property p_addr;
    local_master_state == pmbw_pkg::ST_CODE_ADDR_LOAD && !gnt_n |=>
      !frame_n && ad_oe && cbe_oe && local_master_state == pmbw_pkg::ST_CODE_BUS_TRANS;
  endproperty
  a_addr: assert property (p_addr) else $error("address phase missing");
  property p_req_drop;
    $fell(frame_n) |=> req_n;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("bus request held");
  property p_taken;
    !local_word_taken_n |-> $past(!local_master_ready_n) ##1 local_word_taken_n;
  endproperty
  a_taken: assert property (p_taken) else $error("word strobe misplaced");
  property p_first_data;
    $fell(frame_n) && burst_remaining_count > 8'h01 |=> !frame_n && !irdy_n && local_word_taken_n;
  endproperty
  a_first_data: assert property (p_first_data) else $error("cycle after address wrong");
  property p_count;
    !irdy_n && !trdy_n && local_master_state == pmbw_pkg::ST_CODE_BUS_TRANS |=>
      burst_remaining_count == $past(burst_remaining_count) - 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");
  property p_last;
    local_master_state == pmbw_pkg::ST_CODE_BUS_TRANS && !irdy_n && burst_remaining_count == 8'h01
      |-> frame_n && local_word_taken_n;
  endproperty
  a_last: assert property (p_last) else $error("frame held on last phase");
  property p_turn;
    !irdy_n && !trdy_n && frame_n |=> !frame_oe && !ad_oe && !cbe_oe && irdy_oe && irdy_n_o &&
      burst_remaining_count == 8'h00 && local_master_state == pmbw_pkg::ST_CODE_BUS_TERM &&
      termination_kind == pmbw_pkg::TERM_NORMAL;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround wrong");
  property p_idle;
    local_master_state == pmbw_pkg::ST_CODE_BUS_TERM |=>
      !irdy_oe && !par_oe && local_master_state == pmbw_pkg::ST_CODE_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("irdy or par still driven");
  c_burst: cover property (local_master_state == pmbw_pkg::ST_CODE_BUS_TERM);
  c_single: cover property ($fell(frame_n) ##1 frame_n);
  c_stall: cover property (!irdy_n && local_master_ready_n);
endmodule : pmbw_checker
`default_nettype wire

// *** tb/pmbw_bridge_tb.sv ***
// self-checking bench: bridge and far end joined by one interface
`timescale 1ns/1ps
`default_nettype none
module pmbw_bridge_tb;
  logic core_clk;
  logic rstn;
  logic usr_start;
  logic [31:0] usr_addr;
  logic [3:0] usr_cmd;
  logic [7:0] usr_len;
  logic usr_wvalid;
  logic [31:0] usr_wdata;
  logic [3:0] usr_wbe;
  logic usr_wready;
  logic rx_valid;
  logic [31:0] rx_data;
  logic [3:0] rx_be;
  logic busy;
  int n_errors = 0;
  int n_checks = 0;
  pmbw_if bus();
  pmbw_bridge i_pmbw_bridge (.core_clk(core_clk), .rstn(rstn), .bus(bus), .busy(busy));
  pmbw_far_end i_pmbw_far_end (.core_clk(core_clk), .rstn(rstn), .bus(bus), .usr_start(usr_start),
    .usr_addr(usr_addr), .usr_cmd(usr_cmd), .usr_len(usr_len), .usr_wvalid(usr_wvalid),
    .usr_wdata(usr_wdata), .usr_wbe(usr_wbe), .usr_wready(usr_wready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_be(rx_be));
  pmbw_checker i_pmbw_checker (.core_clk(core_clk), .rstn(rstn),
    .local_req_32bit_n(bus.local_req_32bit_n), .local_grant_n(bus.local_grant_n),
    .local_master_state(bus.local_master_state), .local_master_ready_n(bus.local_master_ready_n),
    .local_word_taken_n(bus.local_word_taken_n), .burst_remaining_count(bus.burst_remaining_count),
    .termination_kind(bus.termination_kind), .req_n(bus.req_n), .gnt_n(bus.gnt_n),
    .trdy_n(bus.trdy_n), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .irdy_n_o(bus.irdy_n_o),
    .irdy_oe(bus.irdy_oe), .frame_oe(bus.frame_oe), .ad_oe(bus.ad_oe), .cbe_oe(bus.cbe_oe),
    .par_oe(bus.par_oe));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic do_reset();
    rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 rstn = 1'b1;
  endtask : do_reset
  // one burst of len words; gap idles the writer between words to stall the buffer
  task automatic burst(input int len, input int gap);
    logic [31:0] addr;
    int got;
    int i;
    int k;
    int w;
    bit seen;
    bit done;
    addr = 32'h10000000 + 32'(len * 16);
    got = 0;
    seen = 1'b0;
    done = 1'b0;
    usr_addr = addr;
    usr_cmd = 4'h7;
    usr_len = 8'(len);
    usr_start = 1'b1;
    @(posedge core_clk);
    #1 usr_start = 1'b0;
    fork
      begin
        for (i = 0; i < len; i++) begin
          usr_wvalid = 1'b1;
          usr_wdata = 32'hA5000000 + 32'(i);
          usr_wbe = 4'(i);
          for (w = 0; w < 200; w++) begin
            @(negedge core_clk);
            if (usr_wready === 1'b1) break;
          end
          @(posedge core_clk);
          #1;
          if (gap > 0 || i == len - 1) usr_wvalid = 1'b0;
          repeat (gap) @(posedge core_clk);
          if (gap > 0) #1;
        end
      end
      begin
        for (k = 0; k < 400 && !done; k++) begin
          @(negedge core_clk);
          if (bus.local_master_state === pmbw_pkg::ST_CODE_BUS_TRANS && !seen) begin
            seen = 1'b1;
            check(bus.ad === addr && bus.cbe === 4'h7, "address phase");
            check(bus.burst_remaining_count === 8'(len), "burst length load");
            check(busy === 1'b1, "busy flag");
          end
          if (rx_valid === 1'b1) begin
            check(rx_data === 32'hA5000000 + 32'(got) && rx_be === 4'(got), "word order");
            got++;
          end
          if (bus.local_master_state === pmbw_pkg::ST_CODE_BUS_TERM) begin
            done = 1'b1;
            check(bus.termination_kind === pmbw_pkg::TERM_NORMAL && got == len, "burst end");
          end
        end
        check(done, "burst hang");
      end
    join
    @(posedge core_clk);
    #1;
  endtask : burst
  initial begin
    rstn = 1'b0;
    usr_start = 1'b0;
    usr_addr = 32'h00000000;
    usr_cmd = 4'h0;
    usr_len = 8'h00;
    usr_wvalid = 1'b0;
    usr_wdata = 32'h00000000;
    usr_wbe = 4'h0;
    do_reset();
    burst(3, 0);
    burst(1, 0);
    burst(8, 3);
    burst(2, 0);
    burst(2, 0);
    // second reset mid-run, then traffic again
    fork
      burst(5, 0);
      begin
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'b0;
      end
    join_any
    disable fork;
    #1;
    usr_wvalid = 1'b0;
    check(busy === 1'b0 && bus.req_n === 1'b1 && bus.frame_oe === 1'b0 && bus.irdy_oe === 1'b0 &&
      bus.local_master_state === pmbw_pkg::ST_CODE_IDLE && rx_valid === 1'b0, "reset state");
    do_reset();
    burst(4, 1);
    complete_run();
  end
  // hangs are cut after 20000 clock cycles, far beyond the expected run length
  initial begin
    #(25 * 20000);
    n_errors++;
    complete_run();
  end
endmodule : pmbw_bridge_tb
`default_nettype wire
